// ==== src/ahp_pkg.sv ====
package ahp_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int AHP_DW = 8;
  localparam int AHP_AW = 8;
  localparam int AHP_TEST_BIT = 7;
  // ----------------------------------------
  // Timing, in ns and in cycles of clk
  // ----------------------------------------
  localparam int AHP_CLK_NS = 20;
  localparam int AHP_SETUP_NS = 40;
  localparam int AHP_STROBE_NS = 100;
  localparam int AHP_HOLD_NS = 40;
  localparam int AHP_RESET_NS = 200;
  localparam logic [3:0] AHP_SETUP_CYC = 4'((AHP_SETUP_NS + AHP_CLK_NS - 1) / AHP_CLK_NS);
  localparam logic [3:0] AHP_STROBE_CYC = 4'((AHP_STROBE_NS + AHP_CLK_NS - 1) / AHP_CLK_NS);
  localparam logic [3:0] AHP_HOLD_CYC = 4'((AHP_HOLD_NS + AHP_CLK_NS - 1) / AHP_CLK_NS);
  localparam logic [3:0] AHP_RESET_CYC = 4'((AHP_RESET_NS + AHP_CLK_NS - 1) / AHP_CLK_NS);
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    AHP_RESET = 3'h0,
    AHP_IDLE = 3'h1,
    AHP_ADDR = 3'h3,
    AHP_LATCH = 3'h2,
    AHP_STROBE = 3'h6,
    AHP_HOLD = 3'h7
  } ahp_state_t;
endpackage

// ==== src/ahp_sync2.sv ====
`timescale 1ns/1ps
module ahp_sync2
  import ahp_pkg::*;
#(
  parameter int W = 9
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } ahp_sync_t;
  ahp_sync_t r;
  ahp_sync_t next_r;
  always_comb begin
    next_r = r;
    if (ce) begin
      next_r.meta = din;
      next_r.sync = r.meta;
    end
  end
  always_ff @(posedge clk) begin
    r <= next_r;
  end
  assign dout = r.sync;
endmodule

// ==== src/ahp_host_ctrl.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Host holds chip select low throughout every read or write access.
// - Strobe-only systems tie chip select to inverted reset; not used here.
// - Read: read strobe low with chip select; device drives data.
// - Write: device captures data on rising write strobe with chip select low.
// - Top address bit high selects test space, low normal space.
// - Host shows address with latch enable high, then drops it.
module ahp_host_ctrl
  import ahp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqWrite,
  input wire logic reqTest,
  input wire logic [AHP_AW-2:0] reqAddr,
  input wire logic [AHP_DW-1:0] reqWdata,
  input wire logic resetReq,
  output logic rspValid,
  output logic [AHP_DW-1:0] rspRdata,
  output logic irqPending,
  output logic chipSelect_n,
  output logic readStrobe_n,
  output logic writeStrobe_n,
  output logic asyncReset_n,
  output logic addressLatchEnable,
  output logic [AHP_AW-1:0] registerAddress,
  input wire logic [AHP_DW-1:0] hostDataIn,
  output logic [AHP_DW-1:0] hostDataOut,
  output logic hostDataOe,
  input wire logic interruptRequest_n
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ahp_state_t st;
    logic [3:0] cnt;
    logic wr;
    logic [AHP_AW-1:0] addr;
    logic [AHP_DW-1:0] wdata;
    logic [AHP_DW-1:0] rdata;
    logic rsp;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic rst_n;
    logic ale;
    logic oe;
  } ahp_ctrl_t;

  ahp_ctrl_t r;
  ahp_ctrl_t next_r;
  logic [AHP_DW:0] syncOut;
  logic [AHP_DW-1:0] dataSync;
  logic irqSync_n;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Read data is only sampled after the strobe has stood long enough to settle
  ahp_sync2 #(
    .W(AHP_DW + 1)
  ) u_sync (
    .clk(clk),
    .ce(ce),
    .din({interruptRequest_n, hostDataIn}),
    .dout(syncOut)
  );
  assign dataSync = syncOut[AHP_DW-1:0];
  assign irqSync_n = syncOut[AHP_DW];

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always_comb begin
    next_r = r;
    if (srst) begin
      next_r = '0;
      next_r.st = AHP_RESET;
      next_r.cnt = AHP_RESET_CYC;
      next_r.cs_n = 1'b1;
      next_r.rd_n = 1'b1;
      next_r.wr_n = 1'b1;
      next_r.ale = 1'b1;
    end else if (ce) begin
      // Pulse drops on enabled cycles or on srst; while ce is low without srst it stands on
      next_r.rsp = 1'b0;
      case (r.st)
        AHP_RESET: begin
          next_r.cs_n = 1'b1;
          next_r.rst_n = 1'b0;
          if (r.cnt == 4'h0) begin
            next_r.rst_n = 1'b1;
            next_r.st = AHP_IDLE;
          end else begin
            next_r.cnt = r.cnt - 4'h1;
          end
        end

        AHP_IDLE: begin
          // Reset request first, so no access can straddle the pulse
          if (resetReq) begin
            next_r.st = AHP_RESET;
            next_r.cnt = AHP_RESET_CYC;
            next_r.rst_n = 1'b0;
          end else if (reqValid) begin
            next_r.addr = {reqTest, reqAddr};
            next_r.wr = reqWrite;
            next_r.wdata = reqWdata;
            next_r.ale = 1'b1;
            next_r.cs_n = 1'b0;
            next_r.cnt = AHP_SETUP_CYC;
            next_r.st = AHP_ADDR;
          end
        end

        AHP_ADDR: begin
          if (r.cnt == 4'h0) begin
            next_r.ale = 1'b0;
            next_r.cnt = AHP_SETUP_CYC;
            next_r.st = AHP_LATCH;
          end else begin
            next_r.cnt = r.cnt - 4'h1;
          end
        end

        AHP_LATCH: begin
          if (r.cnt == 4'h0) begin
            // Write data leads the capture edge by the whole strobe
            next_r.oe = r.wr;
            next_r.rd_n = r.wr;
            next_r.wr_n = ~r.wr;
            next_r.cnt = AHP_STROBE_CYC;
            next_r.st = AHP_STROBE;
          end else begin
            next_r.cnt = r.cnt - 4'h1;
          end
        end

        AHP_STROBE: begin
          if (r.cnt == 4'h0) begin
            if (!r.wr) begin
              next_r.rdata = dataSync;
            end
            // rising write edge, cs still low
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
            next_r.cnt = AHP_HOLD_CYC;
            next_r.st = AHP_HOLD;
          end else begin
            next_r.cnt = r.cnt - 4'h1;
          end
        end

        AHP_HOLD: begin
          // Select and data outlast the strobe edge by the hold time
          if (r.cnt == 4'h0) begin
            next_r.cs_n = 1'b1;
            next_r.oe = 1'b0;
            next_r.ale = 1'b1;
            next_r.rsp = 1'b1;
            next_r.st = AHP_IDLE;
          end else begin
            next_r.cnt = r.cnt - 4'h1;
          end
        end

        default: begin
          // Stray code: park with every strobe released
          next_r.st = AHP_IDLE;
          next_r.cs_n = 1'b1;
          next_r.rd_n = 1'b1;
          next_r.wr_n = 1'b1;
          next_r.oe = 1'b0;
        end
      endcase
    end
  end

  // Reset folded into next_r; keeps it synchronous
  always_ff @(posedge clk) begin
    r <= next_r;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // No new request while busy or while a reset request waits
  assign reqReady = ce && !srst && (r.st == AHP_IDLE) && !resetReq;
  // Pins come straight from flops, so no glitch reaches a strobe
  assign rspValid = r.rsp;
  assign rspRdata = r.rdata;
  assign irqPending = ~irqSync_n;
  assign chipSelect_n = r.cs_n;
  assign readStrobe_n = r.rd_n;
  assign writeStrobe_n = r.wr_n;
  assign asyncReset_n = r.rst_n;
  assign addressLatchEnable = r.ale;
  assign registerAddress = r.addr;
  assign hostDataOut = r.wdata;
  assign hostDataOe = r.oe;
endmodule

// ==== testbench/ahp_dev_model.sv ====
`timescale 1ns/1ps
module ahp_dev_model
  import ahp_pkg::*;
#(
  parameter logic [7:0] ACK_ADDR = 8'h05
) (
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic asyncReset_n,
  input wire logic addressLatchEnable,
  input wire logic [AHP_AW-1:0] registerAddress,
  input wire logic [AHP_DW-1:0] hostDataOut,
  input wire logic hostDataOe,
  input wire logic irqSet,
  output logic [AHP_DW-1:0] hostDataIn,
  output logic interruptRequest_n
);
  logic [7:0] regs [256];
  logic [7:0] lat;
  logic irq;
  always_latch if (addressLatchEnable) lat <= registerAddress;
  always @(posedge writeStrobe_n or negedge asyncReset_n) begin
    if (!asyncReset_n) begin
      foreach (regs[i]) regs[i] <= 8'h00;
      irq <= 1'b0;
    end else if (!chipSelect_n) begin
      regs[lat] <= hostDataIn;
      if (lat == ACK_ADDR) irq <= 1'b0;
    end
  end
  always @(posedge irqSet) irq <= 1'b1;
  // undriven bus shows inverse, never a lucky match
  assign hostDataIn = hostDataOe ? hostDataOut : (!readStrobe_n && !chipSelect_n) ? regs[lat] : ~regs[lat];
  assign interruptRequest_n = !(irq === 1'b1);
endmodule

// ==== testbench/ahp_host_ctrl_chk.sv ====
`timescale 1ns/1ps
module ahp_host_ctrl_chk
  import ahp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic reqTest,
  input wire logic [AHP_AW-2:0] reqAddr,
  input wire logic chipSelect_n,
  input wire logic readStrobe_n,
  input wire logic writeStrobe_n,
  input wire logic asyncReset_n,
  input wire logic addressLatchEnable,
  input wire logic [AHP_AW-1:0] registerAddress,
  input wire logic [AHP_DW-1:0] hostDataOut,
  input wire logic hostDataOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_select_spans_strobe: assert property ((!readStrobe_n || !writeStrobe_n) |-> !chipSelect_n)
    else $error("strobe outside select");
  a_select_off_reset: assert property (!asyncReset_n |-> chipSelect_n)
    else $error("select low during device reset");
  a_strobes_exclusive: assert property (readStrobe_n || writeStrobe_n)
    else $error("both strobes low");
  a_read_floats: assert property (!readStrobe_n |-> !hostDataOe)
    else $error("driving during read");
  a_write_data_held: assert property (!writeStrobe_n && !$past(writeStrobe_n) |-> hostDataOe && $stable(hostDataOut))
    else $error("write data moved");
  a_write_width: assert property ($fell(writeStrobe_n) |-> !writeStrobe_n [*6] ##1 writeStrobe_n)
    else $error("write strobe width");
  a_latch_in_select: assert property (!addressLatchEnable |-> !chipSelect_n)
    else $error("latch closed outside access");
  a_addr_frozen: assert property (!addressLatchEnable && !$past(addressLatchEnable) |-> $stable(registerAddress))
    else $error("address moved while latched");
  a_addr_from_req: assert property (reqValid && reqReady |=> registerAddress == {reqTest, reqAddr})
    else $error("address not from request");
endmodule
bind ahp_host_ctrl ahp_host_ctrl_chk u_ahp_host_ctrl_chk (.clk, .srst, .reqValid, .reqReady, .reqTest, .reqAddr,
  .chipSelect_n, .readStrobe_n, .writeStrobe_n, .asyncReset_n, .addressLatchEnable, .registerAddress, .hostDataOut,
  .hostDataOe);

// ==== testbench/test_async_host_register_port.sv ====
`timescale 1ns/1ps
module test_async_host_register_port
  import ahp_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, ce = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, reqTest = 1'b0;
  logic resetReq = 1'b0, irqSet = 1'b0, reqReady, rspValid, irqPending, chipSelect_n, readStrobe_n;
  logic writeStrobe_n, asyncReset_n, addressLatchEnable, hostDataOe, interruptRequest_n;
  logic [6:0] reqAddr = 7'h00;
  logic [7:0] reqWdata = 8'h00, rspRdata, registerAddress, hostDataIn, hostDataOut, rd;
  int failCount = 0, checkCount = 0, stall = 0;
  always #10 clk = ~clk;
  ahp_host_ctrl u_ahp_host_ctrl (.*);
  ahp_dev_model u_ahp_dev_model (.*);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checkCount++;
    if (seen !== exp) begin
      failCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic t, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    reqWrite = w;
    reqTest = t;
    reqAddr = a;
    reqWdata = d;
    reqValid = 1'b1;
    @(negedge clk);
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(8'(n), 8'(2 * AHP_SETUP_CYC + AHP_STROBE_CYC + AHP_HOLD_CYC + 4 + stall));
    rd = rspRdata;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic rwSpaces();
    logic [6:0] al [3] = '{7'h00, 7'h11, 7'h7f};
    for (int t = 0; t < 2; t++) foreach (al[i]) acc(1'b1, t[0], al[i], {t[0], al[i]} ^ 8'h5a);
    for (int t = 0; t < 2; t++) foreach (al[i]) begin
      acc(1'b0, t[0], al[i], 8'h00);
      chk(rd, {t[0], al[i]} ^ 8'h5a);
    end
  endtask
  task automatic freezeAcc();
    stall = 5;
    fork
      acc(1'b0, 1'b1, 7'h11, 8'h00);
      begin
        repeat (8) @(negedge clk);
        ce = 1'b0;
        repeat (5) @(negedge clk);
        ce = 1'b1;
      end
    join
    stall = 0;
    chk(rd, 8'h91 ^ 8'h5a);
  endtask
  task automatic resetDev();
    resetReq = 1'b1;
    @(negedge clk);
    resetReq = 1'b0;
    chk({7'h00, asyncReset_n}, 8'h00);
    acc(1'b0, 1'b0, 7'h11, 8'h00);
    chk(rd, 8'h00);
  endtask
  task automatic irqTest();
    irqSet = 1'b1;
    repeat (4) @(negedge clk);
    irqSet = 1'b0;
    chk({7'h00, irqPending}, 8'h01);
    acc(1'b1, 1'b0, 7'h05, 8'h00);
    repeat (4) @(negedge clk);
    chk({7'h00, irqPending}, 8'h00);
  endtask
  task automatic testDone();
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    srst = 1'b0;
    rwSpaces();
    freezeAcc();
    resetDev();
    irqTest();
    testDone();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #200000;
    failCount++;
    testDone();
  end
endmodule
